// File: shared/qos_admit_defs.vh
// constants for the buffer admission and egress conditioning block
`ifndef QOS_ADMIT_DEFS_VH
`define QOS_ADMIT_DEFS_VH
// clock and reference line rate
`define CLK_MHZ        10
`define REF_RATE_MBPS  1000
`define SHAPE_FULL     7'h40
`define UNIT_SHIFT     9
// word indexes of the register map (byte address = index * 4)
`define W_DRC_A        6'h00
`define W_DRC_B        6'h01
`define W_SHARED       6'h02
`define W_UCC          6'h03
`define W_LOW          6'h04
`define W_XOFF         6'h05
`define W_MCTH         6'h06
`define W_FCMASK       6'h07
`define W_CLS          6'h08
`define W_PORT         6'h10
`define W_L1           6'h18
`define W_L2           6'h20
`define W_SHP          6'h28
`define W_RC           6'h30
`define W_STAT         6'h38
`define W_CNT          6'h39
`define W_DROPS        6'h3a
`define NCFG           56
// writable bit masks, reserved bits read zero
`define M_PCT2         32'h00007f7f
`define M_CNT          32'h00000fff
`define M_QB           32'h00ffffff
`define M_FC           32'h0000003f
`define M_SHP          32'h0000017f
`define SHP_EN_BIT     8
// buffer regions
`define R_NONE         2'h0
`define R_CLS          2'h1
`define R_SHR          2'h2
`define R_PRT          2'h3
// processor port number and its slot
`define PROC_PORT      4'h8
`define PROC_IDX       3'h5
`endif

// File: src/qos_admit.v
// buffer admission, early drop, shapers, rate control and pause logic
// Operation
// - two thresholds, fractions X Y, then all/Z
// - occupancy is queue byte count, priority queues
// - refused resource drops every frame
// - drop percentages and thresholds are programmable
// - per uplink queue shaper forces strict priority
// - shaped rate is setting/64 of 1000 Mbps
// - shaper may hold frames on idle line
// - reduced ports limit rx and tx independently
// - frames first held in temporary region
// - three class pair reservations, classes 2-7
// - six per source port reservations
// - class, then shared, then source port
// - best effort drop if port lacks buffer
// - congested, shared empty: drop with fraction b
// - congested, port reserve low: drop
// - flow control ports skip scarce drops
// - pause port after programmed slots used
// - release pause once all slots freed
// - multicast pause above global count threshold
// - early drop ignores output flow control
// - size registers for ports, pool, classes
// - flow control traffic goes best effort
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "qos_admit_defs.vh"

////////////////////////////////////////////////////////////////////////
// credit bucket, units of 1/64 bit
module token_bucket #(
  parameter W = 28
) (
  input  wire         sys_clk_i,
  input  wire         rst_b_i,
  input  wire [W-1:0] add_i,    // credit gained each cycle
  input  wire [W-1:0] cap_i,    // burst ceiling
  input  wire         spend_i,  // frame sent
  input  wire [W-1:0] cost_i,   // frame cost
  output wire         ok_o      // credit not negative
);
  reg  signed [W-1:0] credit_reg;
  wire signed [W-1:0] credit_next;
  wire signed [W-1:0] sum;
  // cost may push credit negative; sender then waits
  assign sum = credit_reg + $signed(add_i) - (spend_i ? $signed(cost_i) : $signed({W{1'b0}}));
  assign credit_next = (sum > $signed(cap_i)) ? $signed(cap_i) : sum;
  assign ok_o = ~credit_reg[W-1];
  // credit register
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      credit_reg <= {W{1'b0}};
    else
      credit_reg <= credit_next;
  end
endmodule

////////////////////////////////////////////////////////////////////////
module qos_admit #(
  parameter CW          = 12,    // buffer slot counter width
  parameter QW          = 24,    // queue byte count width
  parameter TEMP_SLOTS  = 12'h020,
  parameter SHAPE_BURST = 24'h000800
) (
  // clock and reset
  input  wire          sys_clk_i,
  input  wire          rst_b_i,
  // avalon-mm slave
  input  wire [7:0]    avs_address_i,
  input  wire          avs_read_i,
  input  wire          avs_write_i,
  input  wire [31:0]   avs_writedata_i,
  input  wire [3:0]    avs_byteenable_i,
  output reg  [31:0]   avs_readdata_o,
  output reg           avs_waitrequest_o,
  // frame arrival into temporary region
  input  wire          rx_start_i,
  output reg           temp_full_o,
  // admission request after switch response
  input  wire          adm_valid_i,
  input  wire [3:0]    adm_port_i,
  input  wire [2:0]    adm_class_i,
  input  wire [1:0]    adm_queue_i,
  input  wire          adm_high_drop_i,
  input  wire          adm_mcast_i,
  input  wire [QW-1:0] adm_qbytes_i,
  output reg           adm_done_o,
  output reg           adm_drop_o,
  output reg  [1:0]    adm_region_o,
  output reg  [1:0]    adm_queue_o,
  // buffer release
  input  wire          rel_valid_i,
  input  wire [3:0]    rel_port_i,
  input  wire [2:0]    rel_class_i,
  input  wire [1:0]    rel_region_i,
  input  wire          rel_mcast_i,
  // uplink transmit, shapers
  input  wire          tx_valid_i,
  input  wire [1:0]    tx_queue_i,
  input  wire [11:0]   tx_len_i,
  output reg  [3:0]    shp_allow_o,
  output reg  [3:0]    shp_strict_o,
  // reduced port rate control, 0-3 rx, 4-7 tx
  input  wire          rc_valid_i,
  input  wire [2:0]    rc_sel_i,
  input  wire [11:0]   rc_len_i,
  output reg  [7:0]    rc_allow_o,
  // pause
  output reg  [5:0]    pause_o,
  output reg           mcast_pause_o
);
  localparam [27:0] REF_BPC = `REF_RATE_MBPS / `CLK_MHZ; // bits per cycle
  localparam [27:0] SH_CAP  = {4'h0, SHAPE_BURST} << `UNIT_SHIFT;

  integer i;
  reg  [31:0]   cfg_reg [0:`NCFG-1];    // register file
  reg  [CW-1:0] cls_used_reg [0:2];     // class pair usage
  reg  [CW-1:0] pt_used_reg [0:5];      // source port usage
  reg  [CW-1:0] sh_used_reg;            // shared pool usage
  reg  [CW-1:0] temp_used_reg;          // temporary region usage
  reg  [CW-1:0] mc_cnt_reg;             // buffered multicast frames
  reg  [15:0]   drops_reg;              // dropped frame count
  reg  [15:0]   lfsr_reg;               // random source

  // per word writable mask, zero for unmapped words
  function [31:0] wmask;
    input [5:0] w;
    begin
      case (w[5:3])
        3'h0:    wmask = (w[2:0] < 3'h2) ? `M_PCT2 : (w[2:0] == 3'h3) ? `M_QB :
                         (w[2:0] == 3'h7) ? `M_FC : `M_CNT;
        3'h1:    wmask = (w[2:0] < 3'h3) ? `M_CNT : 32'h0;
        3'h2:    wmask = (w[2:0] < 3'h6) ? `M_CNT : 32'h0;
        3'h3:    wmask = (w[2:0] < 3'h3) ? `M_QB : 32'h0;
        3'h4:    wmask = (w[2:0] < 3'h3) ? `M_QB : 32'h0;
        3'h5:    wmask = (w[2:0] < 3'h4) ? `M_SHP : 32'h0;
        3'h6:    wmask = `M_QB;
        default: wmask = 32'h0;
      endcase
    end
  endfunction

  // counter step with one increment and one decrement
  function [CW-1:0] step;
    input [CW-1:0] c;
    input          up;
    input          dn;
    begin
      step = c + {{(CW-1){1'b0}}, up} - {{(CW-1){1'b0}}, dn};
    end
  endfunction

  // port number to slot, processor port sits in slot five
  function [2:0] slot;
    input [3:0] p;
    begin
      slot = (p == `PROC_PORT) ? `PROC_IDX : p[2:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: waitrequest drops one cycle after the request,
  // read data stand at that edge, the write lands one edge later
  wire [5:0]  word = avs_address_i[7:2];
  wire        req  = avs_read_i | avs_write_i;
  wire [31:0] be_m = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wr_m = be_m & wmask(word);
  reg  [31:0] rd_val;

  // read mux, unmapped words read zero
  always @*
  begin
    rd_val = 32'h0;
    if (word < `W_STAT)
      rd_val = cfg_reg[word] & wmask(word);
    else if (word == `W_STAT)
      rd_val = {25'h0, mcast_pause_o, pause_o};
    else if (word == `W_CNT)
      rd_val = {4'h0, mc_cnt_reg, 4'h0, sh_used_reg};
    else if (word == `W_DROPS)
      rd_val = {16'h0, drops_reg};
  end

  // bus handshake and register writes
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
      for (i = 0; i < `NCFG; i = i + 1)
        cfg_reg[i] <= 32'h0;
    end
    else if (req && avs_waitrequest_o)
    begin
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= rd_val;
    end
    else
    begin
      avs_waitrequest_o <= 1'b1;
      if (!avs_waitrequest_o && avs_write_i && word < `W_STAT)
        cfg_reg[word] <= (cfg_reg[word] & ~wr_m) | (avs_writedata_i & wr_m);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // config fields
  wire [6:0]    pct_x   = cfg_reg[`W_DRC_A][6:0];
  wire [6:0]    pct_y   = cfg_reg[`W_DRC_A][14:8];
  wire [6:0]    pct_z   = cfg_reg[`W_DRC_B][6:0];
  wire [6:0]    pct_b   = cfg_reg[`W_DRC_B][14:8];
  wire [CW-1:0] sh_size = cfg_reg[`W_SHARED][CW-1:0];
  wire [QW-1:0] unicast_congestion_threshold     = cfg_reg[`W_UCC][QW-1:0];
  wire [CW-1:0] low_thr = cfg_reg[`W_LOW][CW-1:0];
  wire [CW-1:0] xoff_th = cfg_reg[`W_XOFF][CW-1:0];
  wire [CW-1:0] mc_thr  = cfg_reg[`W_MCTH][CW-1:0];
  wire [5:0]    fc_mask = cfg_reg[`W_FCMASK][5:0];

  // per frame random value 0..99
  wire [22:0] prod = lfsr_reg * 7'd100;
  wire [6:0]  rnd  = prod[22:16];

  ////////////////////////////////////////////////////////////////////////
  // admission decision
  wire [2:0]    pidx   = slot(adm_port_i);
  wire          fc     = fc_mask[pidx];
  wire [1:0]    q_eff  = fc ? 2'h0 : adm_queue_i;
  wire          be     = (q_eff == 2'h0);
  wire          has_c  = (adm_class_i[2:1] != 2'h0);
  wire [1:0]    cidx   = adm_class_i[2:1] - 2'h1;
  wire [CW-1:0] pt_res = cfg_reg[`W_PORT + {3'h0, pidx}][CW-1:0];
  wire [CW-1:0] pt_use = pt_used_reg[pidx];
  wire          c_room = has_c &&
                  cls_used_reg[cidx] < cfg_reg[`W_CLS + {4'h0, cidx}][CW-1:0];
  wire          s_room = sh_used_reg < sh_size;
  wire          p_room = pt_use < pt_res;
  wire [1:0]    region = c_room ? `R_CLS : s_room ? `R_SHR :
                         p_room ? `R_PRT : `R_NONE;
  wire          refuse = (region == `R_NONE);
  // early drop thresholds for queue 1..3
  wire [QW-1:0] lv1    = cfg_reg[`W_L1 + {4'h0, q_eff} - 6'h1][QW-1:0];
  wire [QW-1:0] lv2    = cfg_reg[`W_L2 + {4'h0, q_eff} - 6'h1][QW-1:0];
  wire          over2  = adm_qbytes_i > lv2;
  wire          over1  = adm_qbytes_i > lv1;
  wire          ed     = !be && (over2 ? (adm_high_drop_i || rnd < pct_z) :
                         over1 && rnd < (adm_high_drop_i ? pct_x : pct_y));
  // scarce buffer drops, best effort only
  wire          cong   = adm_qbytes_i >= unicast_congestion_threshold;
  wire          scarce = be && !fc && (!p_room ||
                         (cong && !s_room && rnd < pct_b) ||
                         (cong && (pt_res - pt_use) < low_thr));
  wire          drop   = refuse || ed || scarce;
  wire          alloc  = adm_valid_i && !drop;

  // result registers
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      adm_done_o   <= 1'b0;
      adm_drop_o   <= 1'b0;
      adm_region_o <= `R_NONE;
      adm_queue_o  <= 2'h0;
      drops_reg    <= 16'h0;
      lfsr_reg     <= 16'h0001;
    end
    else
    begin
      lfsr_reg   <= {lfsr_reg[14:0],
                     lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      adm_done_o <= adm_valid_i;
      if (adm_valid_i)
      begin
        adm_drop_o   <= drop;
        adm_region_o <= drop ? `R_NONE : region;
        adm_queue_o  <= q_eff;
        if (drop)
          drops_reg <= drops_reg + 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer accounting; an arrival and a release in one cycle both count
  wire [2:0] ridx = slot(rel_port_i);
  wire [1:0] rcix = rel_class_i[2:1] - 2'h1;
  wire       rel_c = rel_valid_i && rel_region_i == `R_CLS;
  wire       rel_s = rel_valid_i && rel_region_i == `R_SHR;
  wire       rel_p = rel_valid_i && rel_region_i == `R_PRT;
  wire       t_up  = rx_start_i && !temp_full_o;

  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sh_used_reg   <= {CW{1'b0}};
      temp_used_reg <= {CW{1'b0}};
      mc_cnt_reg    <= {CW{1'b0}};
      temp_full_o   <= 1'b0;
      for (i = 0; i < 3; i = i + 1)
        cls_used_reg[i] <= {CW{1'b0}};
      for (i = 0; i < 6; i = i + 1)
        pt_used_reg[i] <= {CW{1'b0}};
    end
    else
    begin
      // temporary hold until the switch response decides
      temp_used_reg <= step(temp_used_reg, t_up,
                            adm_valid_i && temp_used_reg != {CW{1'b0}});
      temp_full_o   <= step(temp_used_reg, t_up,
                            adm_valid_i && temp_used_reg != {CW{1'b0}}) >= TEMP_SLOTS;
      sh_used_reg   <= step(sh_used_reg, alloc && region == `R_SHR, rel_s);
      mc_cnt_reg    <= step(mc_cnt_reg, alloc && adm_mcast_i,
                            rel_valid_i && rel_mcast_i);
      for (i = 0; i < 3; i = i + 1)
        cls_used_reg[i] <= step(cls_used_reg[i],
                                alloc && region == `R_CLS && cidx == i,
                                rel_c && rcix == i);
      for (i = 0; i < 6; i = i + 1)
        pt_used_reg[i] <= step(pt_used_reg[i],
                               alloc && region == `R_PRT && pidx == i,
                               rel_p && ridx == i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flow control; port pause only toward flow control capable ports, multicast pause not masked
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pause_o       <= 6'h0;
      mcast_pause_o <= 1'b0;
    end
    else
    begin
      mcast_pause_o <= mc_cnt_reg > mc_thr;
      for (i = 0; i < 6; i = i + 1)
        if (!fc_mask[i])
          pause_o[i] <= 1'b0;
        else if (xoff_th != {CW{1'b0}} && pt_used_reg[i] >= xoff_th)
          pause_o[i] <= 1'b1;
        else if (pt_used_reg[i] == {CW{1'b0}})
          pause_o[i] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // uplink queue shapers and reduced port rate limiters
  wire [3:0] sh_ok;
  wire [7:0] rc_ok;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : shp
      wire [6:0]  raw = cfg_reg[`W_SHP + g][6:0];
      wire [6:0]  set = (raw > `SHAPE_FULL) ? `SHAPE_FULL : raw;
      wire [27:0] add = {21'h0, set} * REF_BPC;
      token_bucket #(.W(28)) u_bkt (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .add_i     (add),
        .cap_i     (SH_CAP),
        .spend_i   (tx_valid_i && tx_queue_i == g),
        .cost_i    ({16'h0, tx_len_i} << `UNIT_SHIFT),
        .ok_o      (sh_ok[g])
      );
    end
    for (g = 0; g < 8; g = g + 1)
    begin : rcb
      wire [31:0] c = cfg_reg[`W_RC + g];
      token_bucket #(.W(28)) u_bkt (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .add_i     ({20'h0, c[7:0]}),
        .cap_i     ({12'h0, c[23:8]} << `UNIT_SHIFT),
        .spend_i   (rc_valid_i && rc_sel_i == g),
        .cost_i    ({16'h0, rc_len_i} << `UNIT_SHIFT),
        .ok_o      (rc_ok[g])
      );
    end
  endgenerate

  // grant registers; a shaped queue waits on credit even when idle
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      shp_allow_o  <= 4'hf;
      shp_strict_o <= 4'h0;
      rc_allow_o   <= 8'hff;
    end
    else
    begin
      rc_allow_o <= rc_ok;
      for (i = 0; i < 4; i = i + 1)
      begin
        shp_strict_o[i] <= cfg_reg[`W_SHP + i][`SHP_EN_BIT];
        shp_allow_o[i]  <= sh_ok[i] || !cfg_reg[`W_SHP + i][`SHP_EN_BIT];
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/qos_admit_monitor.sv
// admission block port checker
`timescale 1ns/1ps
`default_nettype none
`include "qos_admit_defs.vh"
module qos_admit_monitor (
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  // bus and frame side
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic       rx_start_i,
  input wire logic       temp_full_o,
  input wire logic       adm_valid_i,
  input wire logic       adm_done_o,
  input wire logic       adm_drop_o,
  input wire logic [1:0] adm_region_o,
  input wire logic       rel_valid_i,
  input wire logic       rc_valid_i,
  // conditioning outputs
  input wire logic [7:0] rc_allow_o,
  input wire logic [3:0] shp_allow_o,
  input wire logic [3:0] shp_strict_o,
  input wire logic [5:0] pause_o,
  input wire logic       mcast_pause_o
);
  // one domain, so one clocking and one disable
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////
  AST_ADM_DONE: assert property (adm_valid_i |=> adm_done_o)
    else $error("no done");
  AST_DONE_CAUSE: assert property (adm_done_o |-> $past(adm_valid_i))
    else $error("stray done");
  AST_NONE_DROP: assert property (adm_done_o && adm_region_o == `R_NONE |-> adm_drop_o)
    else $error("kept, no region");
  AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("no bus answer");
  AST_BUS_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("wait low too long");
  AST_SHP_FREE: assert property ((shp_strict_o == 4'h0) [*2] |-> shp_allow_o == 4'hf)
    else $error("unshaped held");
  AST_RC_FALL: assert property ((($past(rc_allow_o) & ~rc_allow_o) != 8'h00)
    |-> $past(rc_valid_i) || $past(rc_valid_i, 2))
    else $error("rate closed idle");
  AST_PAUSE_SET: assert property (((pause_o & ~$past(pause_o)) != 6'h00)
    |-> $past(adm_done_o) || $past(!avs_waitrequest_o) || $past(!avs_waitrequest_o, 2))
    else $error("stray pause");
  AST_PAUSE_CLR: assert property (((~pause_o & $past(pause_o)) != 6'h00)
    |-> $past(rel_valid_i) || $past(rel_valid_i, 2) || $past(!avs_waitrequest_o, 2))
    else $error("stray unpause");
  AST_MC_SET: assert property ($rose(mcast_pause_o)
    |-> $past(adm_done_o) || $past(!avs_waitrequest_o) || $past(!avs_waitrequest_o, 2))
    else $error("stray mcast pause");
  AST_TEMP_SET: assert property ($rose(temp_full_o)
    |-> $past(rx_start_i) || $past(rx_start_i, 2))
    else $error("stray temp full");
  // main scenarios reached
  COV_DROP: cover property (adm_done_o && adm_drop_o);
  COV_PAUSE: cover property (pause_o != 6'h00);
  COV_MCAST: cover property (mcast_pause_o);
  COV_SHAPE: cover property (shp_allow_o != 4'hf);
endmodule
bind qos_admit qos_admit_monitor mon (.*);
`default_nettype wire

// File: verification/mac_side_model.sv
// ingress mac and lookup model
`timescale 1ns/1ps
`default_nettype none
module mac_side_model (
  // clock
  input  wire logic        sys_clk_i,
  // arrival and lookup answer
  output var  logic        rx_start_o,
  output var  logic        adm_valid_o,
  output var  logic [3:0]  adm_port_o,
  output var  logic [2:0]  adm_class_o,
  output var  logic [1:0]  adm_queue_o,
  output var  logic        adm_high_drop_o,
  output var  logic        adm_mcast_o,
  output var  logic [23:0] adm_qbytes_o
);
  logic [34:0] fld = '0;  // lookup fields, packed
  assign {adm_port_o, adm_class_o, adm_queue_o, adm_high_drop_o, adm_mcast_o, adm_qbytes_o} = fld;
  // quiet lines at time zero
  initial
  begin
    rx_start_o = 1'b0;
    adm_valid_o = 1'b0;
  end
  // one arrival into the temporary region
  task arrive;
    @(posedge sys_clk_i);
    rx_start_o <= 1'b1;
    @(posedge sys_clk_i);
    rx_start_o <= 1'b0;
  endtask
  // arrival, then lookup answer; fields scrambled after
  task frame(input logic [3:0] p, input logic [2:0] c, input logic [1:0] q,
             input logic hd, input logic mc, input logic [23:0] b);
    arrive();
    adm_valid_o <= 1'b1;
    fld <= {p, c, q, hd, mc, b};
    @(posedge sys_clk_i);
    adm_valid_o <= 1'b0;
    fld <= ~{p, c, q, hd, mc, b};
  endtask
endmodule
`default_nettype wire

// File: verification/qos_admit_tb.sv
// admission block bench
`timescale 1ns/1ps
`default_nettype none
`include "qos_admit_defs.vh"
// compare, count, report at once
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module qos_admit_tb;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic        rel_valid_i = 1'b0;
  logic        rel_mcast_i = 1'b0;
  logic        tx_valid_i = 1'b0;
  logic        rc_valid_i = 1'b0;
  logic [3:0]  rel_port_i = 4'h0;
  logic [1:0]  rel_region_i = 2'h0;
  logic [2:0]  sel = 3'h0;    // shared by tx queue and rate select
  logic [11:0] len = 12'h000; // shared by tx and rate lengths
  wire         rx_start_i, adm_valid_i, adm_high_drop_i, adm_mcast_i;
  wire  [3:0]  adm_port_i;
  wire  [2:0]  adm_class_i;
  wire  [1:0]  adm_queue_i, adm_region_o, adm_queue_o;
  wire  [23:0] adm_qbytes_i;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, temp_full_o, adm_done_o, adm_drop_o, mcast_pause_o;
  wire  [3:0]  shp_allow_o, shp_strict_o;
  wire  [7:0]  rc_allow_o;
  wire  [5:0]  pause_o;
  int          err_total = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [31:0] rdv;
  // small temporary region so it fills quickly
  qos_admit #(.TEMP_SLOTS(12'h004)) uut (.*, .rel_class_i(3'h0), .tx_queue_i(sel[1:0]),
    .tx_len_i(len), .rc_sel_i(sel), .rc_len_i(len));
  mac_side_model mac (.sys_clk_i, .rx_start_o(rx_start_i), .adm_valid_o(adm_valid_i),
    .adm_port_o(adm_port_i), .adm_class_o(adm_class_i), .adm_queue_o(adm_queue_i),
    .adm_high_drop_o(adm_high_drop_i), .adm_mcast_o(adm_mcast_i), .adm_qbytes_o(adm_qbytes_i));
  ////////////////////////////////////////////////////////////
  // 100 ns clock and a hang guard
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  // counts, verdict, stop
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // avalon transfer held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= ~w;
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0)
        @(posedge sys_clk_i);
      rdv = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
    end
  endtask
  // settle on a falling edge after n cycles
  task idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  // mid-run reset, short on purpose
  task reboot;
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
  endtask
  // one frame, judged in its done cycle
  task adm(input logic [3:0] p, input logic [2:0] c, input logic [1:0] q, input logic hd,
           input logic mc, input logic [23:0] b, input logic dr, input logic [1:0] rg);
    begin
      mac.frame(p, c, q, hd, mc, b);
      @(negedge sys_clk_i);
      `CHK(adm_done_o, 1'b1)
      `CHK(adm_drop_o, dr)
      if (!dr)
        `CHK(adm_region_o, rg)
    end
  endtask
  // release one slot of a source port
  task rel(input logic [3:0] p, input logic [1:0] r, input logic mc);
    @(posedge sys_clk_i);
    rel_port_i <= p;
    rel_region_i <= r;
    rel_mcast_i <= mc;
    rel_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    rel_valid_i <= 1'b0;
  endtask
  // uplink send or rate-control charge
  task fire(input logic rc, input logic [2:0] s, input logic [11:0] n);
    @(posedge sys_clk_i);
    sel <= s;
    len <= n;
    tx_valid_i <= ~rc;
    rc_valid_i <= rc;
    @(posedge sys_clk_i);
    tx_valid_i <= 1'b0;
    rc_valid_i <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  // reset values, masks, read-only words, lanes
  task t_regs;
    begin
      bus(0, 8'h00, 0);
      `CHK(rdv, 32'h0)
      bus(1, 8'h00, 32'hffffffff);
      bus(0, 8'h00, 0);
      `CHK(rdv, 32'h00007f7f)
      bus(1, 8'h2c, 32'hffffffff);
      bus(0, 8'h2c, 0);
      `CHK(rdv, 32'h0)
      avs_byteenable_i <= 4'h1;
      bus(1, 8'h08, 32'h00000fff);
      avs_byteenable_i <= 4'hf;
      bus(0, 8'h08, 0);
      `CHK(rdv, 32'h000000ff)
      bus(1, 8'he0, 32'h0000007f);
      bus(0, 8'he0, 0);
      `CHK(rdv, 32'h0)
    end
  endtask
  // class pair, then shared, then port, then refusal
  task t_alloc;
    begin
      reboot();
      bus(1, 8'h20, 32'h2);
      bus(1, 8'h08, 32'h1);
      bus(1, 8'h44, 32'h1);
      adm(1, 1, 1, 0, 0, 0, 0, `R_SHR);
      adm(1, 2, 1, 0, 0, 0, 0, `R_CLS);
      adm(1, 3, 1, 0, 0, 0, 0, `R_CLS);
      adm(1, 2, 1, 0, 0, 0, 0, `R_PRT);
      adm(1, 2, 1, 0, 0, 0, 1, `R_NONE);
      `CHK(adm_region_o, `R_NONE)
      bus(0, 8'he8, 0);
      `CHK(rdv, 32'h1)
    end
  endtask
  // early drop on queue 2, fractions 0 and 100
  task t_wred;
    begin
      reboot();
      bus(1, 8'h24, 32'h8);
      bus(1, 8'h64, 32'h64);
      bus(1, 8'h84, 32'hc8);
      bus(1, 8'h00, 32'h0064);
      adm(0, 4, 2, 1, 0, 100, 0, `R_CLS);
      adm(0, 4, 2, 1, 0, 101, 1, `R_CLS);
      adm(0, 4, 2, 0, 0, 101, 0, `R_CLS);
      adm(0, 4, 2, 0, 0, 201, 0, `R_CLS);
      adm(0, 4, 2, 1, 0, 201, 1, `R_CLS);
      bus(1, 8'h04, 32'h64);
      adm(0, 4, 2, 0, 0, 201, 1, `R_CLS);
      bus(1, 8'h00, 32'h6400);
      adm(0, 4, 2, 0, 0, 150, 1, `R_CLS);
      adm(0, 4, 2, 1, 0, 150, 0, `R_CLS);
    end
  endtask
  // best-effort drops, flow-control exemption
  task t_be;
    begin
      reboot();
      bus(1, 8'h08, 32'h4);
      adm(2, 0, 0, 0, 0, 0, 1, `R_SHR);
      bus(1, 8'h08, 32'h0);
      bus(1, 8'h48, 32'h2);
      bus(1, 8'h0c, 32'h10);
      bus(1, 8'h04, 32'h6400);
      adm(2, 0, 0, 0, 0, 16, 1, `R_PRT);
      bus(1, 8'h04, 32'h0);
      adm(2, 0, 0, 0, 0, 16, 0, `R_PRT);
      bus(1, 8'h10, 32'h3);
      adm(2, 0, 0, 0, 0, 16, 1, `R_PRT);
      adm(2, 0, 0, 0, 0, 15, 0, `R_PRT);
      bus(1, 8'h48, 32'h8);
      bus(1, 8'h1c, 32'h4);
      bus(1, 8'h04, 32'h6400);
      adm(2, 0, 3, 1, 0, 16, 0, `R_PRT);
      `CHK(adm_queue_o, 2'h0)
    end
  endtask
  // unicast pause on port 3 and multicast pause
  task t_pause;
    begin
      reboot();
      bus(1, 8'h4c, 32'h4);
      bus(1, 8'h1c, 32'h8);
      bus(1, 8'h14, 32'h2);
      bus(1, 8'h18, 32'h1);
      adm(3, 0, 1, 0, 1, 0, 0, `R_PRT);
      idle(2);
      `CHK(pause_o, 6'h00)
      `CHK(mcast_pause_o, 1'b0)
      adm(3, 0, 1, 0, 1, 0, 0, `R_PRT);
      idle(2);
      `CHK(pause_o, 6'h08)
      `CHK(mcast_pause_o, 1'b1)
      bus(0, 8'he0, 0);
      `CHK(rdv, 32'h48)
      rel(3, `R_PRT, 1);
      idle(2);
      `CHK(pause_o, 6'h08)
      `CHK(mcast_pause_o, 1'b0)
      rel(3, `R_PRT, 1);
      idle(2);
      `CHK(pause_o, 6'h00)
    end
  endtask
  // shapers, rate buckets, temporary region fill
  task t_cond;
    begin
      reboot();
      bus(1, 8'ha4, 32'h100);
      idle(2);
      `CHK(shp_strict_o, 4'h2)
      `CHK(shp_allow_o, 4'hf)
      fire(0, 3'h1, 12'h001);
      idle(3);
      `CHK(shp_allow_o, 4'hd)
      idle(20);
      `CHK(shp_allow_o, 4'hd)
      bus(1, 8'ha0, 32'h140);
      fire(0, 3'h0, 12'h001);
      idle(3);
      `CHK(shp_allow_o, 4'hd)
      fire(1, 3'h4, 12'h001);
      idle(3);
      `CHK(rc_allow_o, 8'hef)
      fire(1, 3'h0, 12'h001);
      idle(3);
      `CHK(rc_allow_o, 8'hee)
      repeat (4) mac.arrive();
      idle(2);
      `CHK(temp_full_o, 1'b1)
      adm(0, 0, 1, 0, 0, 0, 1, `R_NONE);
      idle(2);
      `CHK(temp_full_o, 1'b0)
    end
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_alloc();
    t_wred();
    t_be();
    t_pause();
    t_cond();
    end_sim();
  end
endmodule
`default_nettype wire
